// *** sfhs_consts.vh ***
// Notes on behaviour
// RL1 - Start-up source turns off when supply reaches turn-on level.
// RL2 - Start-up source turns back on when supply decays to minimum level.
// RL3 - Lockout trip forces gate drive off at once.
// RL4 - Lockout filter timer; recovery resumes drive, expiry enters hiccup.
// RL5 - Thermal or lockout fault enters the double hiccup state.
// RL6 - Hiccup: drive off, low-current mode, discharge to hiccup level.
// RL7 - Two charge/discharge cycles per fault before a restart attempt.
// RL8 - Soft-start begins at the second turn-on crossing of a hiccup.
// RL9 - Fault present or latched at turn-on keeps hiccup, no switching.
// RL10 - Cycling stays above logic reset; latch clears only by reset.
// RL11 - Overload lasting past the overload timer sets the latch flag.
// RL12 - Latched off: keep cycling supply with drive held inactive.
// RL13 - Latch input acts only after full filter delay; glitches ignored.
// RL14 - Skip comparator low suppresses switching cycles.
// RL15 - Start-up source stays off until supply passes the guard level.
// RL16 - Soft-start ramps reference zero to full scale, then holds.
// RL17 - Inputs synchronised; timers count cycles of the clock.
// RL18 - Overload timer restarts from zero when overload goes away.
// RL19 - Thermal indication filtered by a short delay before acting.
`ifndef SFHS_CONSTS_VH
`define SFHS_CONSTS_VH
`define SFHS_CLK_HZ        20000000
`define SFHS_UNDERVOLTAGE_LOCKOUT_US       50
`define SFHS_LATCH_US      50
`define SFHS_THERM_US      75
`define SFHS_OVLD_MS       350
`define SFHS_SSTART_US     4800
`define SFHS_UNDERVOLTAGE_LOCKOUT_CYC      ((`SFHS_UNDERVOLTAGE_LOCKOUT_US * (`SFHS_CLK_HZ / 1000000)))
`define SFHS_LATCH_CYC     ((`SFHS_LATCH_US * (`SFHS_CLK_HZ / 1000000)))
`define SFHS_THERM_CYC     ((`SFHS_THERM_US * (`SFHS_CLK_HZ / 1000000)))
`define SFHS_OVLD_CYC      ((`SFHS_OVLD_MS * (`SFHS_CLK_HZ / 1000)))
`define SFHS_SSTART_CYC    ((`SFHS_SSTART_US * (`SFHS_CLK_HZ / 1000000)))
`define SFHS_REF_W         10
`define SFHS_REF_FULL      10'h3FF
`define SFHS_HICCUPS       2'h2
`endif

// *** sfhs_filter.v ***
`timescale 1ns/100ps
`include "sfhs_consts.vh"
// Qualifies a level: output high once input has been high for LIMIT cycles
module sfhs_filter #(
   parameter W     = 24,
   parameter LIMIT = 1000
) (
   input  wire clk,    // Clock
   input  wire rst_n,  // Async reset
   input  wire level,  // Synchronised level
   output reg  hit     // Qualified level
);
   reg [W-1:0] cnt;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= {W{1'b0}};
         hit <= 1'b0;
      end else if (!level) begin
         // RL18 restart from zero
         cnt <= {W{1'b0}};
         hit <= 1'b0;
      end else if (cnt >= LIMIT[W-1:0] - 1'b1) begin
         hit <= 1'b1;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end
endmodule

// *** sfhs_seq_props.sv ***
`timescale 1ns/100ps
module sfhs_seq_props (
   input wire       CLK,                  // Clock
   input wire       RESET_N,              // Reset
   input wire       SUPPLY_ON,            // Turn-on level
   input wire       SUPPLY_GUARD,         // Guard level
   input wire       UNDERVOLTAGE_LOCKOUT, // Lockout
   input wire       SKIP_LOW,             // Skip
   input wire       STARTUP_EN,           // Source
   input wire       GATE_DRIVE_OUT,       // Drive
   input wire       LOW_CURRENT,          // Low current
   input wire       LATCHED_OFF,          // Latch flag
   input wire       SOFTSTART_ACTIVE,     // Soft-start
   input wire [9:0] SOFTSTART_REFERENCE   // Reference
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   src_off_a: assert property (SUPPLY_ON [*4] |=> !STARTUP_EN)
      else $error("source on above turn-on level");
   guard_off_a: assert property (!SUPPLY_GUARD [*4] |=> !STARTUP_EN)
      else $error("source on below guard level");
   undervoltage_lockout_drive_a: assert property (UNDERVOLTAGE_LOCKOUT [*3] |=> !GATE_DRIVE_OUT)
      else $error("drive on during lockout");
   skip_drive_a: assert property (SKIP_LOW [*3] |=> !GATE_DRIVE_OUT)
      else $error("drive on while skipping");
   hiccup_drive_a: assert property (LOW_CURRENT |=> !GATE_DRIVE_OUT)
      else $error("drive on in hiccup");
   latch_drive_a: assert property (LATCHED_OFF |=> !GATE_DRIVE_OUT)
      else $error("drive on while latched");
   latch_hold_a: assert property (LATCHED_OFF |=> LATCHED_OFF)
      else $error("latch flag cleared without reset");
   ramp_up_a: assert property ((SOFTSTART_ACTIVE && $past(SOFTSTART_ACTIVE))
      |-> SOFTSTART_REFERENCE >= $past(SOFTSTART_REFERENCE))
      else $error("soft-start reference fell");
endmodule

// *** sfhs_sequencer.v ***
`timescale 1ns/100ps
`include "sfhs_consts.vh"
module sfhs_sequencer #(
   parameter OVLD_CYC   = `SFHS_OVLD_CYC,
   parameter SSTART_CYC = `SFHS_SSTART_CYC,
   parameter UNDERVOLTAGE_LOCKOUT_CYC   = `SFHS_UNDERVOLTAGE_LOCKOUT_CYC,
   parameter LATCH_CYC  = `SFHS_LATCH_CYC,
   parameter THERM_CYC  = `SFHS_THERM_CYC
) (
   input  wire                  CLK,           // 20 MHz clock
   input  wire                  RESET_N,       // Logic reset, below 4 V
   input  wire                  SUPPLY_ON,     // Supply above turn-on level
   input  wire                  SUPPLY_MIN,    // Supply above minimum level
   input  wire                  UNDERVOLTAGE_LOCKOUT, // Supply below lockout
   input  wire                  SUPPLY_HICCUP, // Supply above hiccup level
   input  wire                  SUPPLY_GUARD,  // Supply above guard level
   input  wire                  THERMAL_HOT,   // Thermal comparator
   input  wire                  OVERLOAD,      // Overload condition
   input  wire                  LATCH_IN,      // Latch input above threshold
   input  wire                  SKIP_LOW,      // Feedback below skip level
   output reg                   STARTUP_EN,    // HV start-up source on
   output reg                   GATE_DRIVE_OUT,// Gate-drive enable
   output reg                   LOW_CURRENT,   // Low-current mode select
   output reg                   LATCHED_OFF,   // Latched-off flag
   output reg                   SOFTSTART_ACTIVE, // Soft-start running
   output reg [`SFHS_REF_W-1:0] SOFTSTART_REFERENCE // Current limit ref
);
   localparam S_CHARGE = 4'h1;
   localparam S_RUN    = 4'h2;
   localparam S_HCHG   = 4'h4;
   localparam S_HDIS   = 4'h8;

   // RL17 two-flop synchronisers
   reg [8:0] sy1;
   reg [8:0] sy2;
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sy1 <= 9'h000;
         sy2 <= 9'h000;
      end else begin
         sy1 <= {SUPPLY_ON, SUPPLY_MIN, UNDERVOLTAGE_LOCKOUT, SUPPLY_HICCUP,
                 SUPPLY_GUARD, THERMAL_HOT, OVERLOAD, LATCH_IN, SKIP_LOW};
         sy2 <= sy1;
      end
   end
   wire s_on    = sy2[8];
   wire s_min   = sy2[7];
   wire s_uv    = sy2[6];
   wire s_hic   = sy2[5];
   wire s_guard = sy2[4];
   wire s_hot   = sy2[3];
   wire s_ovl   = sy2[2];
   wire s_latch = sy2[1];
   wire s_skip  = sy2[0];

   wire uv_fault;
   wire hot_q;
   wire ovl_q;
   wire latch_q;
   // RL4 lockout filter timer
   sfhs_filter #(.W(12), .LIMIT(UNDERVOLTAGE_LOCKOUT_CYC)) u_uv (
      .clk(CLK), .rst_n(RESET_N), .level(s_uv), .hit(uv_fault));
   // RL19 thermal qualification
   sfhs_filter #(.W(12), .LIMIT(THERM_CYC)) u_th (
      .clk(CLK), .rst_n(RESET_N), .level(s_hot), .hit(hot_q));
   // RL11 overload timer
   sfhs_filter #(.W(24), .LIMIT(OVLD_CYC)) u_ov (
      .clk(CLK), .rst_n(RESET_N), .level(s_ovl), .hit(ovl_q));
   // RL13 latch input filter
   sfhs_filter #(.W(12), .LIMIT(LATCH_CYC)) u_la (
      .clk(CLK), .rst_n(RESET_N), .level(s_latch), .hit(latch_q));

   reg  [3:0]  state;
   reg  [3:0]  next_state;
   reg  [1:0]  hic_cnt;
   reg  [1:0]  next_hic_cnt;
   reg         latched;
   reg  [19:0] ss_cnt;
   reg  [`SFHS_REF_W-1:0] ref_acc;
   reg         ss_run;
   reg         ss_start;
   wire        fault = uv_fault | hot_q;
   wire        latch_set = ovl_q | latch_q;

   always @* begin
      next_state   = state;
      next_hic_cnt = hic_cnt;
      ss_start     = 1'b0;
      case (state)
         S_CHARGE: begin
            if (s_on) begin
               // RL9 fault or latch blocks start
               if (fault || latched) begin
                  next_state   = S_HDIS;
                  next_hic_cnt = 2'h0;
               end else begin
                  next_state = S_RUN;
                  ss_start   = 1'b1;
               end
            end
         end
         S_RUN: begin
            // RL5 thermal or lockout fault
            if (fault || latched || latch_set) begin
               next_state   = S_HDIS;
               next_hic_cnt = 2'h0;
            end
         end
         S_HDIS: begin
            // RL6 discharge to hiccup level
            if (!s_hic) begin
               next_state   = S_HCHG;
               next_hic_cnt = hic_cnt + 2'h1;
            end
         end
         S_HCHG: begin
            if (s_on) begin
               // RL7 two cycles counted; RL8 restart on second
               if (hic_cnt >= `SFHS_HICCUPS && !fault && !latched) begin
                  next_state = S_RUN;
                  ss_start   = 1'b1;
               end else begin
                  // RL12 latched keeps cycling
                  next_state = S_HDIS;
                  if (hic_cnt >= `SFHS_HICCUPS)
                     next_hic_cnt = 2'h0;
               end
            end
         end
         default: begin
            next_state = S_CHARGE;
         end
      endcase
   end

   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state   <= S_CHARGE;
         hic_cnt <= 2'h0;
         latched <= 1'b0;
      end else begin
         state   <= next_state;
         hic_cnt <= next_hic_cnt;
         // RL10 cleared only by reset
         if (latch_set)
            latched <= 1'b1;
      end
   end

   localparam [19:0] SS_LAST = SSTART_CYC[19:0] - 20'h00001;

   // Next ramp count
   function [19:0] ss_step;
      input [19:0] count;
      begin
         ss_step = count + 20'h00001;
      end
   endfunction

   // Reference for a ramp count; the count is 20 bits wide, so the
   // soft-start period is limited to about 50 ms at this clock
   function [`SFHS_REF_W-1:0] ramp_level;
      input [19:0] count;
      reg   [31:0] scaled;
      begin
         scaled     = ({12'h000, count} * {22'h000000, `SFHS_REF_FULL}) /
                      SSTART_CYC;
         ramp_level = scaled[`SFHS_REF_W-1:0];
      end
   endfunction

   // RL16 soft-start ramp
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ss_cnt  <= 20'h00000;
         ref_acc <= {`SFHS_REF_W{1'b0}};
         ss_run  <= 1'b0;
      end else if (ss_start) begin
         ss_cnt  <= 20'h00000;
         ref_acc <= {`SFHS_REF_W{1'b0}};
         ss_run  <= 1'b1;
      end else if (next_state != S_RUN) begin
         ss_run  <= 1'b0;
         ref_acc <= {`SFHS_REF_W{1'b0}};
      end else if (ss_run) begin
         if (ss_cnt >= SS_LAST) begin
            ss_run  <= 1'b0;
            ref_acc <= `SFHS_REF_FULL;
         end else begin
            ss_cnt  <= ss_step(ss_cnt);
            ref_acc <= ramp_level(ss_step(ss_cnt));
         end
      end
   end

   // Source needs two guard samples in a row, so a noisy guard cannot pulse it
   reg startup_arm;
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         STARTUP_EN          <= 1'b0;
         startup_arm         <= 1'b0;
         GATE_DRIVE_OUT      <= 1'b0;
         LOW_CURRENT         <= 1'b0;
         LATCHED_OFF         <= 1'b0;
         SOFTSTART_ACTIVE    <= 1'b0;
         SOFTSTART_REFERENCE <= {`SFHS_REF_W{1'b0}};
      end else begin
         // RL15 guard level; RL1 off at turn-on; RL2 on at minimum
         if (!s_guard)
            startup_arm <= 1'b0;
         else if (s_on)
            startup_arm <= 1'b0;
         else if (!s_min || next_state == S_CHARGE || next_state == S_HCHG)
            startup_arm <= 1'b1;
         STARTUP_EN <= startup_arm & s_guard & ~s_on &
                       (next_state != S_HDIS);
         // RL3 immediate drive off; RL14 skip suppresses cycles
         GATE_DRIVE_OUT <= (next_state == S_RUN) & ~s_uv & ~s_skip &
                           ~fault & ~latched & ~latch_set;
         LOW_CURRENT    <= (next_state == S_HDIS);
         LATCHED_OFF    <= latched | latch_set;
         SOFTSTART_ACTIVE    <= ss_run;
         SOFTSTART_REFERENCE <= ref_acc;
      end
   end
endmodule

// *** sfhs_supply_model.sv ***
`timescale 1ns/100ps
module sfhs_supply_model (
   input  wire clk,     // Clock
   input  wire st_en,   // Start-up source on
   input  wire drv,     // Gate drive active
   input  wire low_cur, // Low-current mode
   input  wire heavy,   // Extra load pulling the supply down
   output wire on_ok,   // Above turn-on
   output wire min_ok,  // Above minimum
   output wire lockout, // Below lockout
   output wire hic_ok,  // Above hiccup level
   output wire guard    // Above guard level
);
   // Supply in 10 mV steps; inhibit current lifts a grounded pin
   // An idle part below the minimum level draws next to nothing
   int vcc = 0;
   always @(negedge clk) begin
      vcc <= vcc + (st_en ? 4 : 0) + (vcc < 67 ? 2 : 0)
             - (heavy ? 6 : 0)
             - ((drv && !low_cur) ? 2 : ((low_cur || vcc >= 990) ? 1 : 0));
   end
   assign on_ok   = vcc >= 1270;
   assign min_ok  = vcc >= 990;
   assign lockout = vcc < 940;
   assign hic_ok  = vcc > 570;
   assign guard   = vcc >= 67;
endmodule

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
   logic       CLK, RESET_N, THERMAL_HOT, OVERLOAD, LATCH_IN, SKIP_LOW, lp;
   logic       heavy;
   wire        SUPPLY_ON, SUPPLY_MIN, UNDERVOLTAGE_LOCKOUT, SUPPLY_HICCUP;
   wire        SUPPLY_GUARD, STARTUP_EN, GATE_DRIVE_OUT, LOW_CURRENT;
   wire        LATCHED_OFF, SOFTSTART_ACTIVE;
   wire  [9:0] SOFTSTART_REFERENCE;
   int         bad_count, checked, t, n, len;
   always #25 CLK = ~CLK;
   sfhs_supply_model i_sfhs_supply_model (.clk(CLK), .st_en(STARTUP_EN),
      .heavy(heavy),
      .drv(GATE_DRIVE_OUT), .low_cur(LOW_CURRENT), .on_ok(SUPPLY_ON),
      .min_ok(SUPPLY_MIN), .lockout(UNDERVOLTAGE_LOCKOUT),
      .hic_ok(SUPPLY_HICCUP), .guard(SUPPLY_GUARD));
   sfhs_sequencer #(.OVLD_CYC(200), .SSTART_CYC(100), .UNDERVOLTAGE_LOCKOUT_CYC(40),
      .LATCH_CYC(40), .THERM_CYC(60)) i_sfhs_sequencer (.CLK, .RESET_N,
      .SUPPLY_ON, .SUPPLY_MIN, .UNDERVOLTAGE_LOCKOUT, .SUPPLY_HICCUP,
      .SUPPLY_GUARD, .THERMAL_HOT, .OVERLOAD, .LATCH_IN, .SKIP_LOW,
      .STARTUP_EN, .GATE_DRIVE_OUT, .LOW_CURRENT, .LATCHED_OFF,
      .SOFTSTART_ACTIVE, .SOFTSTART_REFERENCE);
   task chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(negedge CLK);
   endtask
   function automatic logic qual(input int l, input int lim);
      return l >= lim;
   endfunction
   task run_up;
      t = 0;
      while (GATE_DRIVE_OUT !== 1'b1 && t < 5000) begin
         cyc(1);
         t++;
      end
      if (t >= 5000) bad_count++;
   endtask
   task finish_test;
      $display("Checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Whole run needs about 10000 cycles; allow six times that
   initial begin
      #3000000;
      bad_count++;
      finish_test;
   end
   initial begin
      CLK = 0; RESET_N = 0; THERMAL_HOT = 0; OVERLOAD = 0; LATCH_IN = 0;
      SKIP_LOW = 0; bad_count = 0; checked = 0;
      heavy = 0;
      void'($urandom(74));
      cyc(20);
      chk("reset outputs", {LATCHED_OFF, GATE_DRIVE_OUT}, 0);
      RESET_N = 1;
      cyc(10);
      chk("source below guard", STARTUP_EN, 0);
      run_up;
      chk("source at turn-on", STARTUP_EN, 0);
      cyc(2);
      chk("ramp running", SOFTSTART_ACTIVE, 1);
      t = 0;
      while (SOFTSTART_ACTIVE === 1'b1 && t < 500) begin cyc(1); t++; end
      chk("ramp end", SOFTSTART_REFERENCE, 10'h3FF);
      t = 0;
      while (STARTUP_EN !== 1'b1 && t < 1000) begin cyc(1); t++; end
      chk("source at minimum", STARTUP_EN, 1);
      $display("Test startup done");
      len = $urandom_range(8, 4);
      SKIP_LOW = 1;
      cyc(len);
      chk("drive in skip", GATE_DRIVE_OUT, 0);
      SKIP_LOW = 0;
      run_up;
      chk("drive after skip", GATE_DRIVE_OUT, 1);
      $display("Test skip done");
      heavy = 1;
      t = 0;
      while (UNDERVOLTAGE_LOCKOUT !== 1'b1 && t < 400) begin
         cyc(1);
         t++;
      end
      heavy = 0;
      cyc(3);
      chk("drive at lockout", GATE_DRIVE_OUT, 0);
      cyc(7);
      chk("lockout recovery", LOW_CURRENT, 0);
      run_up;
      chk("drive resumed", GATE_DRIVE_OUT, 1);
      heavy = 1;
      t = 0;
      while (LOW_CURRENT !== 1'b1 && t < 400) begin
         cyc(1);
         t++;
      end
      heavy = 0;
      chk("lockout expiry", {GATE_DRIVE_OUT, LOW_CURRENT}, 10'h001);
      t = 0;
      while (SOFTSTART_ACTIVE !== 1'b1 && t < 20000) begin
         cyc(1);
         t++;
      end
      chk("lockout restart", SOFTSTART_ACTIVE, 1);
      $display("Test lockout done");
      run_up;
      len = $urandom_range(50, 1);
      THERMAL_HOT = 1;
      cyc(len);
      THERMAL_HOT = 0;
      cyc(5);
      chk("thermal glitch", LOW_CURRENT, qual(len, 60));
      THERMAL_HOT = 1;
      t = 0;
      while (LOW_CURRENT !== 1'b1 && t < 200) begin cyc(1); t++; end
      THERMAL_HOT = 0;
      chk("hiccup entry", {GATE_DRIVE_OUT, LOW_CURRENT}, 10'h001);
      n = 1; lp = 1; t = 0;
      while (SOFTSTART_ACTIVE !== 1'b1 && t < 20000) begin
         cyc(1);
         t++;
         if (LOW_CURRENT && !lp) n++;
         lp = LOW_CURRENT;
      end
      chk("hiccup count", n, 2);
      $display("Test hiccup done");
      run_up;
      len = $urandom_range(30, 1);
      LATCH_IN = 1;
      cyc(len);
      LATCH_IN = 0;
      cyc(5);
      chk("latch glitch", LATCHED_OFF, qual(len, 40));
      LATCH_IN = 1;
      cyc(60);
      LATCH_IN = 0;
      chk("latch set", LATCHED_OFF, 1);
      n = 0; len = 0; lp = STARTUP_EN;
      repeat (4000) begin
         cyc(1);
         len = len | GATE_DRIVE_OUT;
         if (STARTUP_EN && !lp) n++;
         lp = STARTUP_EN;
      end
      chk("drive while latched", len, 0);
      chk("latched cycling", n >= 2, 1);
      chk("flag held", LATCHED_OFF, 1);
      RESET_N = 0;
      cyc(20);
      RESET_N = 1;
      cyc(3);
      chk("flag cleared", LATCHED_OFF, 0);
      $display("Test latch done");
      run_up;
      len = $urandom_range(150, 101);
      OVERLOAD = 1;
      cyc(len);
      OVERLOAD = 0;
      cyc(1);
      OVERLOAD = 1;
      cyc(len);
      OVERLOAD = 0;
      cyc(5);
      chk("overload restart", LATCHED_OFF, 0);
      OVERLOAD = 1;
      cyc(210);
      OVERLOAD = 0;
      cyc(3);
      chk("overload latch", LATCHED_OFF, 1);
      $display("Test overload done");
      finish_test;
   end
endmodule
bind sfhs_sequencer sfhs_seq_props i_props (.CLK, .RESET_N, .SUPPLY_ON,
   .SUPPLY_GUARD, .UNDERVOLTAGE_LOCKOUT, .SKIP_LOW, .STARTUP_EN,
   .GATE_DRIVE_OUT, .LOW_CURRENT, .LATCHED_OFF, .SOFTSTART_ACTIVE,
   .SOFTSTART_REFERENCE);
